/* File: inc/sts_map.vh */
`ifndef STS_MAP_VH
`define STS_MAP_VH
// register byte offsets
`define STS_REG_CTRL 12'h000
`define STS_REG_TEST 12'h004
`define STS_REG_STAT 12'h008
`define STS_REG_FAIL 12'h00c
`define STS_REG_MON 12'h010
`define STS_REG_RCNT 12'h014
`define STS_REG_RATE 12'h018
`define STS_REG_VERS 12'h01c
// ctrl fields
`define STS_CTRL_GO 0
`define STS_CTRL_VIS 1
`define STS_CTRL_ROUTE_LO 4
`define STS_CTRL_RESET 32'h000000f0
// test register fields: [7:0] result valid strobes, [15:8] pass bits, [16] background
`define STS_TEST_PASS_LO 8
`define STS_TEST_BG 16
`define STS_NTEST 8
`define STS_FAIL_LIMIT 2'h3
`define STS_RESET_LIMIT 3'h4
`define STS_NMON 4
// timing, 250 MHz
`define STS_CLK_MHZ 250
`define STS_MON_MS 1000
`define STS_HOUR_S 3600
`define STS_RECOV_MS 1000
`define STS_MON_CYC (`STS_MON_MS * 1000 * `STS_CLK_MHZ)
`define STS_RECOV_CYC (`STS_RECOV_MS * 1000 * `STS_CLK_MHZ)
`define STS_HOUR_CYC (64'd3600 * 64'd1000000 * 64'd250)
`endif

/* File: core/sts_fail_filter.v */
`timescale 1ns/100ps
// consecutive-failure filter for one test
module sts_fail_filter
(
  input wire aclk,
  input wire aresetn,
  input wire valid,
  input wire pass,
  output reg failed
);
`include "sts_map.vh"
  reg [1:0] cnt_ff;
  reg [1:0] nxt_cnt;
  always @*
  begin
    nxt_cnt = cnt_ff;
    if (valid && pass)
      nxt_cnt = 2'h0;
    else if (valid && cnt_ff != `STS_FAIL_LIMIT)
      nxt_cnt = cnt_ff + 2'h1;
  end
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 2'h0;
      failed <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      failed <= (nxt_cnt == `STS_FAIL_LIMIT);
    end
  end
endmodule

/* File: core/sts_persist_timer.v */
`timescale 1ns/100ps
// persistence timer: done once cond held for LIMIT cycles
module sts_persist_timer
#(
  parameter LIMIT = 250000000
)
(
  input wire aclk,
  input wire aresetn,
  input wire cond,
  output reg done
);
  reg [31:0] cnt_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 32'h0;
      done <= 1'b0;
    end
    else if (!cond)
    begin
      cnt_ff <= 32'h0;
      done <= 1'b0;
    end
    else if (cnt_ff >= LIMIT[31:0] - 32'h1)
      done <= 1'b1;
    else
      cnt_ff <= cnt_ff + 32'h1;
  end
endmodule

/* File: core/sts_supervisor.v */
`timescale 1ns/100ps
`include "sts_map.vh"
// Function
// - critical power-up failure halts start-up, saves status, reports, drives critical alarm
// - both processors self-test and exchange; protection starts only after both pass
// - firmware versions must match and stored model must match configuration
// - on clean start-up read magnetics rating to choose 1 A or 5 A
// - enable outputs after init, then decide green indicator from all results
// - show startup banner after program memory test and display init
// - background tests run only when processor idle, never blocking ports
// - background failure declared only after three consecutive fails
// - most critical run-time failures force a recovery reset
// - distinguish power-up from malfunction reset; rerun only the failed hardware tests
// - successful reset records nothing, critical alarm de-energized during reset; red indicator during reset
// - failed reset shuts down board; display shows only failures latched since the recovery reset ended
// - at most four resets per hour; fifth goes to critical halt
// - recovery reset takes about one second
// - foreground I/O tests only when port idle, some each sample period
// - foreground failure counted only after three consecutive fails
// - trip circuit continuity monitored as a foreground test
// - trip unit up without fault detector for 1 s raises non-critical alarm
// - four monitor flags routed to non-critical alarm by default, also exported
// - critical alarm energized normally, de-energized when out of service
module sts_supervisor
#(
  parameter MON_CYC = `STS_MON_CYC,
  parameter RECOV_CYC = `STS_RECOV_CYC,
  parameter HOUR_CYC = 40'd900000000000,
  parameter [31:0] FW_VERSION = 32'h00000001 // arbitrary value
)
(
  input wire aclk,
  input wire aresetn,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire trip_unit_up,
  input wire fault_detector,
  input wire [3:0] port_busy,
  output reg critical_alarm,
  output reg noncrit_alarm,
  output reg green_led,
  output reg red_led,
  output reg outputs_enable,
  output reg protection_on,
  output reg startup_banner_text,
  output reg rating_5a,
  output reg board_shutdown,
  output reg [3:0] monitor_flags,
  output reg [7:0] display_code,
  output reg visual_test
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SELF = 3'h1;
  localparam ST_INIT = 3'h2;
  localparam ST_RUN = 3'h3;
  localparam ST_RECOV = 3'h4;
  localparam ST_HALT = 3'h5;
  localparam ST_DOWN = 3'h6;

  // async pins through two flops
  reg [5:0] pin_s1_ff;
  reg [5:0] pin_s2_ff;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_ff <= 6'h0;
      pin_s2_ff <= 6'h0;
    end
    else
    begin
      pin_s1_ff <= {port_busy, fault_detector, trip_unit_up};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire trip_s = pin_s2_ff[0];
  wire fd_s = pin_s2_ff[1];
  wire [3:0] busy_s = pin_s2_ff[5:2];

  reg [31:0] ctrl_ff;
  reg [7:0] vld_ff;
  reg [7:0] pass_ff;
  reg bg_ff;
  reg [2:0] st_ff;
  reg [7:0] crit_mask_ff;
  reg [7:0] rerun_ff;
  reg [2:0] rcnt_ff;
  reg [39:0] hour_ff;
  reg [31:0] recov_ff;
  reg [31:0] stat_ff;
  reg [7:0] fail_lat_ff;
  reg power_up_ff;
  reg [31:0] rate_ff;
  reg [31:0] mon_ff;
  wire [7:0] failed;
  wire mon_done;
  wire recov_end = (st_ff == ST_RECOV) && (recov_ff >= RECOV_CYC - 32'h1);

  // per-test filters; tests 0..3 are foreground ports, test 7 is trip circuit
  genvar gi;
  generate
    for (gi = 0; gi < `STS_NTEST; gi = gi + 1)
    begin : g_filt
      wire busy_gate = (gi < 4) ? busy_s[gi % 4] : 1'b0;
      sts_fail_filter u_filt
      (
        .aclk(aclk),
        .aresetn(aresetn & ~(recov_end & rerun_ff[gi])),
        .valid(vld_ff[gi] & ~busy_gate),
        .pass(pass_ff[gi]),
        .failed(failed[gi])
      );
    end
  endgenerate

  sts_persist_timer #(.LIMIT(MON_CYC)) u_mon
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .cond(trip_s & ~fd_s),
    .done(mon_done)
  );

  function sel;
    input [11:0] addr;
    input [11:0] off;
    begin
      sel = (addr[11:2] == off[11:2]);
    end
  endfunction

  // axi write
  reg [11:0] aw_ff;
  reg aw_got_ff;
  reg [31:0] wd_ff;
  reg w_got_ff;
  wire wr_go = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  wire wr_ok = sel(aw_ff, `STS_REG_CTRL) | sel(aw_ff, `STS_REG_TEST) | sel(aw_ff, `STS_REG_RATE);
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_ff <= 12'h0;
      wd_ff <= 32'h0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_ff <= s_axi_wdata;
        w_got_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  wire wr_ctrl = wr_go & sel(aw_ff, `STS_REG_CTRL);
  wire wr_test = wr_go & sel(aw_ff, `STS_REG_TEST);
  wire wr_rate = wr_go & sel(aw_ff, `STS_REG_RATE);

  // axi read
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (sel(s_axi_araddr, `STS_REG_CTRL))
        s_axi_rdata <= ctrl_ff;
      else if (sel(s_axi_araddr, `STS_REG_STAT))
        s_axi_rdata <= stat_ff;
      else if (sel(s_axi_araddr, `STS_REG_FAIL))
        s_axi_rdata <= {24'h0, fail_lat_ff};
      else if (sel(s_axi_araddr, `STS_REG_MON))
        s_axi_rdata <= mon_ff;
      else if (sel(s_axi_araddr, `STS_REG_RCNT))
        s_axi_rdata <= {29'h0, rcnt_ff};
      else if (sel(s_axi_araddr, `STS_REG_RATE))
        s_axi_rdata <= rate_ff;
      else if (sel(s_axi_araddr, `STS_REG_VERS))
        s_axi_rdata <= FW_VERSION;
      else
      begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h2;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // test results and control
  wire [7:0] wstb = wd_ff[7:0];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_ff <= `STS_CTRL_RESET;
      vld_ff <= 8'h0;
      pass_ff <= 8'h0;
      bg_ff <= 1'b0;
      rate_ff <= 32'h0;
    end
    else
    begin
      vld_ff <= wr_test ? wstb : 8'h0;
      if (wr_test)
      begin
        pass_ff <= wd_ff[15:8];
        bg_ff <= wd_ff[`STS_TEST_BG];
      end
      if (wr_ctrl)
        ctrl_ff <= wd_ff;
      else
        ctrl_ff[`STS_CTRL_GO] <= 1'b0;
      if (wr_rate)
        rate_ff <= wd_ff;
    end
  end

  // stat word: [0] cpu0 pass [1] cpu1 pass [2] fw ok [3] model ok [4] prog mem ok [5] display ok [6] rating 5a
  wire self_ok = stat_ff[0] & stat_ff[1];
  wire cfg_ok = stat_ff[2] & stat_ff[3];
  wire crit_fail = |(failed & crit_mask_ff);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= ST_IDLE;
      stat_ff <= 32'h0;
      crit_mask_ff <= 8'h0f;
      rerun_ff <= 8'hff;
      recov_ff <= 32'h0;
      fail_lat_ff <= 8'h0;
      power_up_ff <= 1'b1;
      rcnt_ff <= 3'h0;
      hour_ff <= 40'h0;
    end
    else
    begin
      if (wr_rate)
        stat_ff <= wd_ff;
      fail_lat_ff <= fail_lat_ff | failed;
      // rolling one-hour reset count, held through recovery resets
      if (rcnt_ff != 3'h0)
      begin
        if (hour_ff >= HOUR_CYC - 40'h1)
        begin
          hour_ff <= 40'h0;
          rcnt_ff <= rcnt_ff - 3'h1;
        end
        else
          hour_ff <= hour_ff + 40'h1;
      end
      case (st_ff)
        ST_IDLE:
          if (ctrl_ff[`STS_CTRL_GO])
            st_ff <= ST_SELF;
        ST_SELF:
          if (!self_ok || !cfg_ok)
            st_ff <= power_up_ff ? ST_HALT : ST_DOWN;
          else
            st_ff <= ST_INIT;
        ST_INIT:
          st_ff <= ST_RUN;
        ST_RUN:
          if (crit_fail && bg_ff)
          begin
            power_up_ff <= 1'b0;
            rerun_ff <= failed & crit_mask_ff;
            if (rcnt_ff == `STS_RESET_LIMIT)
              st_ff <= ST_HALT;
            else
            begin
              rcnt_ff <= rcnt_ff + 3'h1;
              recov_ff <= 32'h0;
              st_ff <= ST_RECOV;
            end
          end
        ST_RECOV:
          if (recov_end)
          begin
            st_ff <= ST_IDLE;
            fail_lat_ff <= 8'h0;
          end
          else
            recov_ff <= recov_ff + 32'h1;
        ST_HALT:
          st_ff <= ST_HALT;
        ST_DOWN:
          st_ff <= ST_DOWN;
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  // outputs
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      critical_alarm <= 1'b0;
      noncrit_alarm <= 1'b0;
      green_led <= 1'b0;
      red_led <= 1'b0;
      outputs_enable <= 1'b0;
      protection_on <= 1'b0;
      startup_banner_text <= 1'b0;
      rating_5a <= 1'b0;
      board_shutdown <= 1'b0;
      monitor_flags <= 4'h0;
      display_code <= 8'h0;
      visual_test <= 1'b0;
      mon_ff <= 32'h0;
    end
    else
    begin
      critical_alarm <= (st_ff == ST_RUN) && !crit_fail;
      protection_on <= (st_ff == ST_RUN) && self_ok;
      outputs_enable <= (st_ff == ST_RUN);
      green_led <= (st_ff == ST_RUN) && (fail_lat_ff == 8'h0) && cfg_ok;
      red_led <= (st_ff == ST_RECOV) || (st_ff == ST_HALT) || (st_ff == ST_DOWN);
      startup_banner_text <= (st_ff == ST_SELF || st_ff == ST_INIT) && stat_ff[4] && stat_ff[5];
      if (st_ff == ST_INIT)
        rating_5a <= stat_ff[6];
      board_shutdown <= (st_ff == ST_DOWN);
      display_code <= fail_lat_ff | rerun_ff & {8{st_ff == ST_RECOV}};
      monitor_flags <= {failed[6], fail_lat_ff[5], mon_done, failed[7]};
      noncrit_alarm <= |({failed[6], fail_lat_ff[5], mon_done, failed[7]} & ctrl_ff[7:4]);
      mon_ff <= {28'h0, failed[6], fail_lat_ff[5], mon_done, failed[7]};
      visual_test <= ctrl_ff[`STS_CTRL_VIS] && (st_ff == ST_RUN);
    end
  end
endmodule

/* File: sim/sts_supervisor_props.sv */
`timescale 1ns/100ps
module sts_supervisor_props
#(
  parameter MON_CYC = 20
)
(
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire trip_unit_up,
  input wire fault_detector,
  input wire noncrit_alarm,
  input wire [3:0] monitor_flags
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // cycles the raw monitor condition has held
  reg [31:0] run_ff;
  wire [31:0] nxt_run = (trip_unit_up && !fault_detector) ? run_ff + 32'h1 : 32'h0;
  always @(posedge aclk)
  begin
    if (!aresetn)
      run_ff <= 32'h0;
    else
      run_ff <= nxt_run;
  end
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response changed early");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while response pending");
  reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !noncrit_alarm)
    else $error("outputs not idle after reset");
  mon_persist_a: assert property ($rose(monitor_flags[1]) |-> run_ff >= MON_CYC - 1)
    else $error("monitor flag before persistence time");
  alarm_quiet_a: assert property ((monitor_flags == 4'h0) [*2] |-> !noncrit_alarm)
    else $error("noncritical alarm without any flag");
  cover property (monitor_flags[1]);
  cover property (monitor_flags[0] && noncrit_alarm);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule

bind sts_supervisor sts_supervisor_props #(.MON_CYC(MON_CYC)) sts_supervisor_props_i (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .trip_unit_up(trip_unit_up), .fault_detector(fault_detector), .noncrit_alarm(noncrit_alarm),
  .monitor_flags(monitor_flags));

/* File: sim/sts_companion_model.sv */
`timescale 1ns/100ps
// mode 0 quiet, 1 trip unit up alone, 2 trip with detector, 3 ports busy
module sts_companion_model
(
  input wire aclk,
  input wire [1:0] mode,
  output reg trip_unit_up = 1'b0,
  output reg fault_detector = 1'b0,
  output reg [3:0] port_busy = 4'h0
);
  always @(posedge aclk)
  begin
    trip_unit_up <= (mode == 2'h1) || (mode == 2'h2);
    fault_detector <= (mode == 2'h2);
    port_busy <= {4{mode == 2'h3}};
  end
endmodule

/* File: sim/test_sts_supervisor.sv */
`timescale 1ns/100ps
`include "sts_map.vh"
module test_sts_supervisor;
  localparam MON = 20;
  localparam [31:0] VER = 32'h00005a5a; // arbitrary value
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [11:0] awaddr = 12'h000;
  reg [11:0] araddr = 12'h000;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  reg [1:0] mode = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, tup, fdet, ncrit;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] pbusy, mflags;
  wire crit, green, red, oen, prot, r5, shut, vis;
  wire [7:0] dcode;
  integer miscompares = 0, num_checks = 0, n;
  always #2 aclk = ~aclk;
  sts_companion_model sts_companion_model_i (.aclk(aclk), .mode(mode), .trip_unit_up(tup),
    .fault_detector(fdet), .port_busy(pbusy));
  sts_supervisor #(.MON_CYC(MON), .RECOV_CYC(20), .HOUR_CYC(40'd1000), .FW_VERSION(VER)) sts_supervisor_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trip_unit_up(tup), .fault_detector(fdet), .port_busy(pbusy), .critical_alarm(crit),
    .noncrit_alarm(ncrit), .green_led(green), .red_led(red), .outputs_enable(oen), .protection_on(prot),
    .startup_banner_text(), .rating_5a(r5), .board_shutdown(shut), .monitor_flags(mflags), .display_code(dcode),
    .visual_test(vis));
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  task chk(input string what, input [31:0] exp, input [31:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task timeout_hit;
  begin
    miscompares = miscompares + 1;
    $display("FAIL wait expected answer seen timeout");
    tally_and_finish;
  end
  endtask
  task wr(input [11:0] a, input [31:0] d, input [1:0] er);
    reg got;
  begin
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    got = 1'b0;
    n = 0;
    while (!got && n < 100)
    begin
      @(posedge aclk);
      n = n + 1;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid === 1'b1)
      begin
        got = 1'b1;
        bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
      end
    end
    if (!got)
      timeout_hit;
    @(posedge aclk);
  end
  endtask
  task rdc(input [11:0] a, input [31:0] exp, input [1:0] er);
    reg got;
  begin
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    got = 1'b0;
    n = 0;
    while (!got && n < 100)
    begin
      @(posedge aclk);
      n = n + 1;
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid === 1'b1)
      begin
        got = 1'b1;
        rready <= 1'b0;
        chk("rdata", exp, rdata);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
      end
    end
    if (!got)
      timeout_hit;
    @(posedge aclk);
  end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge aclk);
  endtask
  task go_run(input [31:0] st);
  begin
    wr(`STS_REG_RATE, st, 2'h0);
    wr(`STS_REG_CTRL, 32'hf1, 2'h0);
    wt(4);
  end
  endtask
  task fail0;
    repeat (3) wr(`STS_REG_TEST, 32'h10001, 2'h0);
  endtask
  task rst;
  begin
    aresetn <= 1'b0;
    wt(2);
    aresetn <= 1'b1;
    wt(1);
  end
  endtask
  task wait_flag(input integer b);
  begin
    n = 0;
    while (mflags[b] !== 1'b1 && n < 200)
    begin
      @(posedge aclk);
      n = n + 1;
    end
    chk("monitor flag", 32'h1, {31'h0, mflags[b]});
  end
  endtask
  initial
  begin
    #40000;
    timeout_hit;
  end
  initial
  begin
    wt(8);
    aresetn <= 1'b1;
    wt(1);
    rdc(`STS_REG_CTRL, `STS_CTRL_RESET, 2'h0);
    rdc(`STS_REG_RCNT, 32'h0, 2'h0);
    rdc(`STS_REG_VERS, VER, 2'h0);
    rdc(12'h020, 32'h0, 2'h2);
    wr(12'h020, 32'hffffffff, 2'h2);
    rdc(`STS_REG_CTRL, `STS_CTRL_RESET, 2'h0);
    $display("register test done");
    go_run(32'h3);
    chk("red", 32'h1, {31'h0, red});
    chk("critical", 32'h0, {31'h0, crit});
    chk("protection", 32'h0, {31'h0, prot});
    chk("shutdown", 32'h0, {31'h0, shut});
    rst;
    go_run(32'h7f);
    chk("critical", 32'h1, {31'h0, crit});
    chk("protection", 32'h1, {31'h0, prot});
    chk("outputs", 32'h1, {31'h0, oen});
    chk("green", 32'h1, {31'h0, green});
    chk("rating", 32'h1, {31'h0, r5});
    chk("red", 32'h0, {31'h0, red});
    wr(`STS_REG_CTRL, 32'hf2, 2'h0);
    chk("visual", 32'h1, {31'h0, vis});
    $display("start-up test done");
    wr(`STS_REG_TEST, 32'h80, 2'h0);
    wr(`STS_REG_TEST, 32'h80, 2'h0);
    wr(`STS_REG_TEST, 32'h8080, 2'h0);
    wr(`STS_REG_TEST, 32'h80, 2'h0);
    wr(`STS_REG_TEST, 32'h80, 2'h0);
    wt(4);
    chk("trip flag", 32'h0, {31'h0, mflags[0]});
    wr(`STS_REG_TEST, 32'h80, 2'h0);
    wait_flag(0);
    chk("noncrit", 32'h1, {31'h0, ncrit});
    rdc(`STS_REG_FAIL, 32'h80, 2'h0);
    chk("green", 32'h0, {31'h0, green});
    repeat (3) wr(`STS_REG_TEST, 32'h10040, 2'h0);
    wait_flag(3);
    $display("failure filter test done");
    mode <= 2'h2;
    wt(40);
    mode <= 2'h1;
    wt(10);
    mode <= 2'h0;
    wt(30);
    chk("monitor flag", 32'h0, {31'h0, mflags[1]});
    mode <= 2'h1;
    wait_flag(1);
    mode <= 2'h0;
    $display("continuous monitor test done");
    wr(`STS_REG_CTRL, 32'h0, 2'h0);
    wt(4);
    chk("noncrit", 32'h0, {31'h0, ncrit});
    wr(`STS_REG_CTRL, 32'h80, 2'h0);
    wt(4);
    chk("noncrit", 32'h1, {31'h0, ncrit});
    $display("alarm routing test done");
    wr(`STS_REG_TEST, 32'hc0c0, 2'h0);
    mode <= 2'h3;
    wt(6);
    fail0;
    wt(4);
    chk("red", 32'h0, {31'h0, red});
    mode <= 2'h0;
    wt(6);
    fail0;
    wt(2);
    chk("red", 32'h1, {31'h0, red});
    chk("critical", 32'h0, {31'h0, crit});
    chk("display", 32'hc1, {24'h0, dcode});
    wt(30);
    chk("red", 32'h0, {31'h0, red});
    rdc(`STS_REG_RCNT, 32'h1, 2'h0);
    rdc(`STS_REG_FAIL, 32'h0, 2'h0);
    wr(`STS_REG_CTRL, 32'hf1, 2'h0);
    wt(4);
    chk("critical", 32'h1, {31'h0, crit});
    chk("green", 32'h1, {31'h0, green});
    $display("recovery test done");
    repeat (3)
    begin
      fail0;
      wt(32);
      wr(`STS_REG_CTRL, 32'hf1, 2'h0);
      wt(4);
    end
    fail0;
    wt(4);
    chk("red", 32'h1, {31'h0, red});
    chk("critical", 32'h0, {31'h0, crit});
    chk("shutdown", 32'h0, {31'h0, shut});
    rdc(`STS_REG_RCNT, 32'h4, 2'h0);
    wt(1200);
    rdc(`STS_REG_RCNT, 32'h3, 2'h0);
    $display("reset limit test done");
    rst;
    go_run(32'h7f);
    fail0;
    wt(32);
    go_run(32'h0);
    chk("shutdown", 32'h1, {31'h0, shut});
    chk("red", 32'h1, {31'h0, red});
    $display("failed recovery test done");
    tally_and_finish;
  end
endmodule
